/* File: inc/afo_regs.svh */
// Register offsets, field positions, reset values and limits of the filter and orientation bank.
// Contract
// - High-pass select 1 puts filtered samples on the output, 0 unfiltered; default 0.
// - Full-scale field 00/01/10 select 2g/4g/8g; 11 is reserved.
// - After reset range is 2g and the high-pass output is off.
// - Pulse bypass bit 0 filters pulse path through high-pass, 1 bypasses; default 0.
// - Pulse low-pass bit 0 disables pulse low-pass, 1 enables; default 0.
// - Two-bit cut-off select picks the high-pass corner; default 00.
// - Corner depends on code, rate and mode; 800 Hz gives 16..2 Hz, as high-resolution.
// - Low-noise mode at 12.5 Hz or slower gives 0.5 to 0.063 Hz corners.
// - Status bit 7 shows any orientation change; other fields give the orientation.
// - Change flag sets on first detection after activation and on any field change.
// - Any status read clears the change flag and its interrupt source; a change accepted in the same cycle as the read leaves the flag set.
// - Lockout bit reads 1 once the Z-tilt trip angle is exceeded; default 0.
// - Orientation field: 00 portrait up, 01 down, 10 landscape right, 11 left.
// - Back/front bit reads 0 for front, 1 for back.
// - At power-up back/front, orientation and lockout are all zero.
// - Orientation fields keep tracking while the change flag is set.
// - Orientation result holds while any axis magnitude exceeds 1.25g.
// - Interrupt source is flag and enable; a status read clears it; a change accepted with the read keeps it set while enabled.
// - Detection runs only while its enable is 1; enable defaults to 0.
`ifndef AFO_REGS_SVH
`define AFO_REGS_SVH

`define AFO_ADDR_RANGE_CFG   8'h0E
`define AFO_ADDR_HP_CUTOFF   8'h0F
`define AFO_ADDR_ORIENT_STAT 8'h10

`define AFO_RANGE_HPOUT_BIT  4
`define AFO_RANGE_FS_LSB     0
`define AFO_RANGE_RST        8'h00
`define AFO_RANGE_MASK       8'h13

`define AFO_HP_BYP_BIT       5
`define AFO_HP_LPF_BIT       4
`define AFO_HP_SEL_LSB       0
`define AFO_HP_RST           8'h00
`define AFO_HP_MASK          8'h33

`define AFO_STAT_FLAG_BIT    7
`define AFO_STAT_LOCK_BIT    6
`define AFO_STAT_LANDSCAPE_PORTRAIT_FIELD_LSB    1
`define AFO_STAT_BACK_FRONT_BIT_BIT   0

`define AFO_LOCK_MILLI_G     1250
`define AFO_COUNTS_PER_G_2G  1024
`define AFO_CORNER_TOP_MHZ   16000
`define AFO_ODR_12P5_IDX     3'h5

`endif

/* File: inc/afo_pkg.sv */
// Types shared by the filter and orientation register bank.
package afo_pkg;
    typedef enum logic [1:0] {
        OS_NORMAL = 2'h0,
        OS_LNLP   = 2'h1,
        OS_HIRES  = 2'h2,
        OS_LP     = 2'h3
    } afo_osmode_e;

    typedef enum logic [1:0] {
        FS_2G  = 2'h0,
        FS_4G  = 2'h1,
        FS_8G  = 2'h2,
        FS_RSV = 2'h3
    } afo_fs_e;

    typedef enum logic [1:0] {
        OR_IDLE  = 2'h0,
        OR_ARMED = 2'h1,
        OR_TRACK = 2'h3
    } afo_orstate_e;
endpackage

/* File: hdl/afo_filter_orient_regs.sv */
// Range, high-pass and orientation status register bank with orientation tracking.
`timescale 1ns/1ns
`include "afo_regs.svh"

module afo_filter_orient_regs #(
    parameter int DATA_W = 12
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [7:0]        regAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regWrEn,
    input  wire logic              regRdEn,
    output logic      [7:0]        regRdData,
    input  wire logic [2:0]        odrIndex,
    input  wire logic [1:0]        overSampleMode,
    input  wire logic              sampleValid,
    input  wire logic [DATA_W-1:0] rawSample,
    input  wire logic [DATA_W-1:0] filteredSample,
    output logic      [DATA_W-1:0] outSample,
    output logic      [1:0]        fullScaleField,
    output logic                   highpassOutputSelect,
    output logic                   pulseHighpassBypass,
    output logic                   pulseLowpassEnable,
    output logic      [1:0]        cutoffSelect,
    output logic      [3:0]        cornerShift,
    output logic      [15:0]       cornerMilliHz,
    input  wire logic              activeMode,
    input  wire logic              orientationDetectEnable,
    input  wire logic              orientIrqEnable,
    input  wire logic              detValid,
    input  wire logic [1:0]        detLandscapePortrait,
    input  wire logic              detBackFront,
    input  wire logic              detLockout,
    input  wire logic [DATA_W-1:0] axisX,
    input  wire logic [DATA_W-1:0] axisY,
    input  wire logic [DATA_W-1:0] axisZ,
    output logic                   orientationChangeFlag,
    output logic                   tiltLockout,
    output logic      [1:0]        landscapePortraitField,
    output logic                   backFrontBit,
    output logic                   orientIrqSource
);

    localparam int LIMIT_2G = (`AFO_LOCK_MILLI_G * `AFO_COUNTS_PER_G_2G) / 1000;

    logic [7:0]                rangeCfg_reg;
    logic [7:0]                hpCutoff_reg;
    logic                      flag_reg;
    logic                      flag_next;
    logic                      lock_reg;
    logic [1:0]                landscape_portrait_field_reg;
    logic                      back_front_bit_reg;
    logic                      irq_reg;
    logic                      activePrev_reg;
    afo_pkg::afo_orstate_e     state_reg;
    afo_pkg::afo_orstate_e     state_next;
    logic [DATA_W-1:0]         limit;
    logic [DATA_W-1:0]         magX;
    logic [DATA_W-1:0]         magY;
    logic [DATA_W-1:0]         magZ;
    logic                      overLimit;
    logic                      accept;
    logic                      differs;
    logic                      setEvent;
    logic                      statRead;
    logic [3:0]                shift_next;

    // Register writes; reserved bits are masked so they always read zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rangeCfg_reg <= `AFO_RANGE_RST;
            hpCutoff_reg <= `AFO_HP_RST;
        end else if (regWrEn) begin
            if (regAddr == `AFO_ADDR_RANGE_CFG) begin
                rangeCfg_reg <= regWrData & `AFO_RANGE_MASK;
            end
            if (regAddr == `AFO_ADDR_HP_CUTOFF) begin
                hpCutoff_reg <= regWrData & `AFO_HP_MASK;
            end
        end
    end

    assign highpassOutputSelect = rangeCfg_reg[`AFO_RANGE_HPOUT_BIT];
    assign fullScaleField       = rangeCfg_reg[`AFO_RANGE_FS_LSB +: 2];
    assign pulseHighpassBypass  = hpCutoff_reg[`AFO_HP_BYP_BIT];
    assign pulseLowpassEnable   = hpCutoff_reg[`AFO_HP_LPF_BIT];
    assign cutoffSelect         = hpCutoff_reg[`AFO_HP_SEL_LSB +: 2];

    // Output data path selection.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            outSample <= '0;
        end else if (sampleValid) begin
            outSample <= highpassOutputSelect ? filteredSample : rawSample;
        end
    end

    // Corner frequency is 16 Hz halved once per step; the step count depends on mode, rate and cut-off select.
    always_comb begin
        shift_next = 4'h0;
        unique case (afo_pkg::afo_osmode_e'(overSampleMode))
            afo_pkg::OS_HIRES: shift_next = 4'h0;
            afo_pkg::OS_NORMAL: begin
                if (odrIndex >= 3'h4) begin
                    shift_next = 4'h3;
                end else if (odrIndex >= 3'h1) begin
                    shift_next = 4'(odrIndex - 3'h1);
                end
            end
            afo_pkg::OS_LNLP: begin
                if (odrIndex >= `AFO_ODR_12P5_IDX) begin
                    shift_next = 4'h5;
                end else if (odrIndex >= 3'h1) begin
                    shift_next = 4'(odrIndex - 3'h1);
                end
            end
            afo_pkg::OS_LP: begin
                if (odrIndex >= `AFO_ODR_12P5_IDX) begin
                    shift_next = 4'h6;
                end else begin
                    shift_next = {1'b0, odrIndex};
                end
            end
        endcase
        shift_next = shift_next + {2'h0, cutoffSelect};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cornerShift   <= 4'h0;
            cornerMilliHz <= 16'(`AFO_CORNER_TOP_MHZ);
        end else begin
            cornerShift   <= shift_next;
            cornerMilliHz <= 16'(`AFO_CORNER_TOP_MHZ) >> shift_next;
        end
    end

    // Lock limit in counts scales with the selected range; code 11 falls back to 2g.
    always_comb begin
        unique case (afo_pkg::afo_fs_e'(fullScaleField))
            afo_pkg::FS_4G: limit = DATA_W'(LIMIT_2G / 2);
            afo_pkg::FS_8G: limit = DATA_W'(LIMIT_2G / 4);
            default:        limit = DATA_W'(LIMIT_2G);
        endcase
    end

    // The most negative sample wraps to its true magnitude when read unsigned.
    assign magX      = axisX[DATA_W-1] ? DATA_W'(-axisX) : axisX;
    assign magY      = axisY[DATA_W-1] ? DATA_W'(-axisY) : axisY;
    assign magZ      = axisZ[DATA_W-1] ? DATA_W'(-axisZ) : axisZ;
    assign overLimit = (magX > limit) || (magY > limit) || (magZ > limit);

    // Detection results are taken only when running and not over the lock limit.
    assign accept  = detValid && (state_reg != afo_pkg::OR_IDLE) && !overLimit;
    assign differs = (detLandscapePortrait != landscape_portrait_field_reg) || (detBackFront != back_front_bit_reg)
                     || (detLockout != lock_reg);
    assign setEvent = accept && (differs || (state_reg == afo_pkg::OR_ARMED));
    assign statRead = regRdEn && (regAddr == `AFO_ADDR_ORIENT_STAT);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            afo_pkg::OR_IDLE: begin
                if (orientationDetectEnable && activeMode) begin
                    state_next = afo_pkg::OR_ARMED;
                end
            end
            afo_pkg::OR_ARMED: begin
                if (accept) begin
                    state_next = afo_pkg::OR_TRACK;
                end
            end
            afo_pkg::OR_TRACK: state_next = afo_pkg::OR_TRACK;
            default:           state_next = afo_pkg::OR_IDLE;
        endcase
        // Falling back to standby re-arms the first-detection report.
        if (!orientationDetectEnable || !activeMode || (activeMode && !activePrev_reg)) begin
            state_next = (orientationDetectEnable && activeMode) ?
                         afo_pkg::OR_ARMED : afo_pkg::OR_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg      <= afo_pkg::OR_IDLE;
            activePrev_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            activePrev_reg <= activeMode;
        end
    end

    // Fields follow every accepted detection, whether or not the flag is pending.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            landscape_portrait_field_reg  <= 2'h0;
            back_front_bit_reg <= 1'b0;
            lock_reg  <= 1'b0;
        end else if (accept) begin
            landscape_portrait_field_reg  <= detLandscapePortrait;
            back_front_bit_reg <= detBackFront;
            lock_reg  <= detLockout;
        end
    end

    // A change arriving with the clearing read survives it.
    assign flag_next = setEvent ? 1'b1 : (statRead ? 1'b0 : flag_reg);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_reg <= 1'b0;
            irq_reg  <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            irq_reg  <= flag_next && orientIrqEnable;
        end
    end

    assign orientationChangeFlag  = flag_reg;
    assign tiltLockout            = lock_reg;
    assign landscapePortraitField = landscape_portrait_field_reg;
    assign backFrontBit           = back_front_bit_reg;
    assign orientIrqSource        = irq_reg;

    // Read data is registered; unmapped addresses return zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            unique case (regAddr)
                `AFO_ADDR_RANGE_CFG:   regRdData <= rangeCfg_reg;
                `AFO_ADDR_HP_CUTOFF:   regRdData <= hpCutoff_reg;
                `AFO_ADDR_ORIENT_STAT: regRdData <= {flag_reg, lock_reg, 3'h0,
                                                     landscape_portrait_field_reg, back_front_bit_reg};
                default:               regRdData <= 8'h00;
            endcase
        end
    end

    sequence seqActivate;
        !activeMode ##1 (activeMode && orientationDetectEnable);
    endsequence

    sequence seqFirstAccept;
        detValid && !overLimit && (state_reg == afo_pkg::OR_ARMED);
    endsequence

    sequence seqCleanRead;
        statRead && !setEvent;
    endsequence

    AST_HPF_MUX: assert property (@(posedge clk) disable iff (sys_rst)
        sampleValid |=> outSample == ($past(highpassOutputSelect) ?
                        $past(filteredSample) : $past(rawSample)))
        else $error("Output sample did not follow the high-pass select.");

    AST_RESET_DEFAULTS: assert property (@(posedge clk)
        sys_rst |=> (fullScaleField == 2'h0) && !highpassOutputSelect && !pulseHighpassBypass
                    && !pulseLowpassEnable && (cutoffSelect == 2'h0))
        else $error("Configuration not at defaults after reset.");

    AST_STATUS_RESET: assert property (@(posedge clk)
        sys_rst |=> !tiltLockout && !backFrontBit && (landscapePortraitField == 2'h0)
                    && !orientationChangeFlag)
        else $error("Orientation status not zero after reset.");

    AST_HIRES_CORNER: assert property (@(posedge clk) disable iff (sys_rst)
        (overSampleMode == afo_pkg::OS_HIRES) |=> cornerShift == {2'h0, $past(cutoffSelect)})
        else $error("High-resolution corner depends on rate.");

    AST_LNLP_CORNER: assert property (@(posedge clk) disable iff (sys_rst)
        (overSampleMode == afo_pkg::OS_LNLP) && (odrIndex >= 3'h5)
        |=> cornerMilliHz == (16'h01F4 >> $past(cutoffSelect)))
        else $error("Slow low-noise corner wrong.");

    AST_FIRST_DET: assert property (@(posedge clk) disable iff (sys_rst)
        seqActivate ##1 seqFirstAccept |=> orientationChangeFlag)
        else $error("First detection after activation did not raise the flag.");

    AST_CHANGE_SETS: assert property (@(posedge clk) disable iff (sys_rst)
        accept && (detBackFront != backFrontBit) |=> orientationChangeFlag ##0
        (backFrontBit == $past(detBackFront)))
        else $error("Back/front change not flagged.");

    AST_READ_CLEARS: assert property (@(posedge clk) disable iff (sys_rst)
        seqCleanRead |=> !orientationChangeFlag && !orientIrqSource)
        else $error("Status read did not clear flag and source.");

    AST_SET_WINS: assert property (@(posedge clk) disable iff (sys_rst)
        statRead && setEvent |=> orientationChangeFlag)
        else $error("Change lost against a clearing read.");

    AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        overLimit |=> $stable(landscapePortraitField) && $stable(backFrontBit)
                      && $stable(tiltLockout))
        else $error("Orientation moved while over the lock limit.");

    AST_IRQ_SOURCE: assert property (@(posedge clk) disable iff (sys_rst)
        orientIrqSource |-> orientationChangeFlag && $past(orientIrqEnable))
        else $error("Interrupt source without flag and enable.");

    AST_DISABLED: assert property (@(posedge clk) disable iff (sys_rst)
        !orientationDetectEnable [*2] |-> !setEvent && (state_reg == afo_pkg::OR_IDLE))
        else $error("Detection ran while disabled.");

    // Each write lands whole on the next cycle; only reserved bits are dropped.
    AST_RANGE_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        regWrEn && (regAddr == `AFO_ADDR_RANGE_CFG)
        |=> (fullScaleField == $past(regWrData[`AFO_RANGE_FS_LSB +: 2]))
            && (highpassOutputSelect == $past(regWrData[`AFO_RANGE_HPOUT_BIT])))
        else $error("Range register write did not land.");

    AST_CUTOFF_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        regWrEn && (regAddr == `AFO_ADDR_HP_CUTOFF)
        |=> (pulseHighpassBypass == $past(regWrData[`AFO_HP_BYP_BIT]))
            && (pulseLowpassEnable == $past(regWrData[`AFO_HP_LPF_BIT]))
            && (cutoffSelect == $past(regWrData[`AFO_HP_SEL_LSB +: 2])))
        else $error("High-pass register write did not land.");

    AST_STATUS_READ: assert property (@(posedge clk) disable iff (sys_rst)
        statRead |=> regRdData == {$past(orientationChangeFlag), $past(tiltLockout), 3'h0,
                                   $past(landscapePortraitField), $past(backFrontBit)})
        else $error("Status read returned the wrong layout.");

    AST_TOP_RATE: assert property (@(posedge clk) disable iff (sys_rst)
        (odrIndex == 3'h0) |=> cornerShift == {2'h0, $past(cutoffSelect)})
        else $error("Fastest-rate corner depends on mode.");

    AST_FIELDS_FOLLOW: assert property (@(posedge clk) disable iff (sys_rst)
        accept |=> (landscapePortraitField == $past(detLandscapePortrait))
                   && (backFrontBit == $past(detBackFront))
                   && (tiltLockout == $past(detLockout)))
        else $error("Orientation fields stopped tracking accepted results.");

    AST_STANDBY_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        !activeMode [*2] |-> (state_reg == afo_pkg::OR_IDLE))
        else $error("Detection armed while in standby.");

    AST_IRQ_SET: assert property (@(posedge clk) disable iff (sys_rst)
        setEvent && orientIrqEnable |=> orientIrqSource)
        else $error("Enabled change did not raise the interrupt source.");

    AST_FLAG_CAUSE: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(orientationChangeFlag) |-> $past(setEvent))
        else $error("Change flag rose without a change.");

endmodule

/* File: dv/afo_host_model.sv */
// Host model that drives the register strobes of the filter and orientation bank.
`timescale 1ns/1ns
`include "afo_regs.svh"

module afo_host_model (
    input  wire logic       clk,
    output logic      [7:0] regAddr = 8'h00,
    output logic      [7:0] regWrData = 8'h00,
    output logic            regWrEn = 1'b0,
    output logic            regRdEn = 1'b0,
    input  wire logic [7:0] regRdData
);
    // A write of the reserved range code is dropped, since the range would be undefined.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = !(a == `AFO_ADDR_RANGE_CFG && d[1:0] == 2'h3);
        @(negedge clk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask

    // Idle address is inverted so a stale value never reads as a match.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
    endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the filter and orientation register bank.
`timescale 1ns/1ns
`include "afo_regs.svh"

module testbench;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} afo_row_s;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  regAddr, regWrData, regRdData, rdv;
    logic        regWrEn, regRdEn, sampleValid = 1'b0, activeMode = 1'b0;
    logic [2:0]  odrIndex = 3'h0;
    logic [1:0]  overSampleMode = 2'h0, detLandscapePortrait = 2'h0;
    logic        orientationDetectEnable = 1'b1, orientIrqEnable = 1'b1;
    logic        detValid = 1'b0, detBackFront = 1'b0, detLockout = 1'b0;
    logic [11:0] rawSample = 12'h123, filteredSample = 12'h456, outSample;
    logic [11:0] axisX = 12'h000, axisY = 12'h000, axisZ = 12'h000;
    logic [1:0]  fullScaleField, cutoffSelect, landscapePortraitField;
    logic [3:0]  cornerShift;
    logic [15:0] cornerMilliHz;
    logic        highpassOutputSelect, pulseHighpassBypass, pulseLowpassEnable;
    logic        orientationChangeFlag, tiltLockout, backFrontBit, orientIrqSource;
    int          n_errors = 0, checked = 0, cycles = 0;
    logic [3:0]  baseShift [4][8] = '{'{0, 0, 1, 2, 3, 3, 3, 3}, '{0, 0, 1, 2, 3, 5, 5, 5},
                                      '{0, 0, 0, 0, 0, 0, 0, 0}, '{0, 1, 2, 3, 4, 6, 6, 6}};
    afo_row_s    rows [8] = '{'{8'h0E, 8'hEE, 8'h02}, '{8'h0E, 8'h01, 8'h01},
                              '{8'h0F, 8'hFF, 8'h33}, '{8'h0F, 8'h10, 8'h10},
                              '{8'h0F, 8'h20, 8'h20}, '{8'h10, 8'hFF, 8'h00},
                              '{8'h20, 8'h5A, 8'h00}, '{8'h0E, 8'h10, 8'h10}};

    always #25 clk = ~clk;

    afo_host_model u_afo_host_model (.clk, .regAddr, .regWrData, .regWrEn, .regRdEn,
                                     .regRdData);
    afo_filter_orient_regs u_afo_filter_orient_regs (
        .clk, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .odrIndex,
        .overSampleMode, .sampleValid, .rawSample, .filteredSample, .outSample,
        .fullScaleField, .highpassOutputSelect, .pulseHighpassBypass, .pulseLowpassEnable,
        .cutoffSelect, .cornerShift, .cornerMilliHz, .activeMode, .orientationDetectEnable,
        .orientIrqEnable, .detValid, .detLandscapePortrait, .detBackFront, .detLockout,
        .axisX, .axisY, .axisZ, .orientationChangeFlag, .tiltLockout,
        .landscapePortraitField, .backFrontBit, .orientIrqSource);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // The whole sequence needs under 2000 cycles; the ceiling leaves ample margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic det(input logic [1:0] lp, input logic bf, input logic lo);
        @(negedge clk);
        detValid = 1'b1;
        detLandscapePortrait = lp;
        detBackFront = bf;
        detLockout = lo;
        @(negedge clk);
        detValid = 1'b0;
    endtask

    task automatic stat(input logic [7:0] exp);
        u_afo_host_model.rd(`AFO_ADDR_ORIENT_STAT, rdv);
        chk(rdv, exp);
    endtask

    task automatic samp(input logic [11:0] exp);
        @(negedge clk);
        sampleValid = 1'b1;
        @(negedge clk);
        sampleValid = 0;
        chk(outSample, exp);
    endtask

    task automatic rstchk();
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        chk({fullScaleField, highpassOutputSelect}, 3'h0);
        chk(cornerMilliHz, 16'h3E80);
        chk({tiltLockout, landscapePortraitField, backFrontBit}, 4'h0);
        u_afo_host_model.rd(`AFO_ADDR_RANGE_CFG, rdv);
        chk(rdv, 8'h00);
        u_afo_host_model.rd(`AFO_ADDR_HP_CUTOFF, rdv);
        chk(rdv, 8'h00);
        stat(8'h00);
    endtask

    initial begin
        rstchk();
        foreach (rows[i]) begin
            u_afo_host_model.wr(rows[i].a, rows[i].d);
            u_afo_host_model.rd(rows[i].a, rdv);
            chk(rdv, rows[i].q);
            if (rows[i].a == `AFO_ADDR_RANGE_CFG)
                chk({highpassOutputSelect, fullScaleField},
                    {rows[i].q[4], rows[i].q[1:0]});
            if (rows[i].a == `AFO_ADDR_HP_CUTOFF)
                chk({pulseHighpassBypass, pulseLowpassEnable, cutoffSelect},
                    {rows[i].q[5:4], rows[i].q[1:0]});
        end
        samp(12'h456);
        u_afo_host_model.wr(`AFO_ADDR_RANGE_CFG, 8'h00);
        samp(12'h123);
        for (int c = 0; c < 4; c++) begin
            u_afo_host_model.wr(`AFO_ADDR_HP_CUTOFF, 8'(c));
            for (int m = 0; m < 4; m++)
                for (int r = 0; r < 8; r++) begin
                    @(negedge clk);
                    overSampleMode = 2'(m);
                    odrIndex = 3'(r);
                    repeat (3) @(negedge clk);
                    chk(16'(cornerShift), 16'(baseShift[m][r] + c));
                    chk(cornerMilliHz, 16'(`AFO_CORNER_TOP_MHZ >> (baseShift[m][r] + c)));
                end
        end
        @(negedge clk);
        activeMode = 1'b1;
        // Detecting on the first armed cycle exercises the first-report check.
        det(2'h0, 1'b0, 1'b0);
        chk({orientationChangeFlag, orientIrqSource}, 2'h3);
        stat(8'h80);
        chk({orientationChangeFlag, orientIrqSource}, 2'h0);
        det(2'h0, 1'b0, 1'b0);
        chk(orientationChangeFlag, 1'b0);
        for (int k = 1; k < 4; k++) begin
            det(2'(k), k[0], 1'b0);
            stat({1'b1, 4'h0, 2'(k), k[0]});
        end
        det(2'h2, 1'b0, 1'b0);
        det(2'h1, 1'b1, 1'b0);
        chk({landscapePortraitField, backFrontBit}, 3'h3);
        stat(8'h83);
        axisX = 12'h501;
        det(2'h2, 1'b0, 1'b1);
        chk({orientationChangeFlag, tiltLockout, landscapePortraitField}, 4'h1);
        axisX = 12'h500;
        axisZ = 12'hAFF;
        det(2'h2, 1'b0, 1'b1);
        chk(orientationChangeFlag, 1'b0);
        axisZ = 12'h000;
        det(2'h2, 1'b0, 1'b1);
        stat(8'hC4);
        u_afo_host_model.wr(`AFO_ADDR_RANGE_CFG, 8'h02);
        axisX = 12'h141;
        det(2'h0, 1'b0, 1'b0);
        chk(orientationChangeFlag, 1'b0);
        axisX = 12'h140;
        det(2'h0, 1'b0, 1'b0);
        stat(8'h80);
        u_afo_host_model.wr(`AFO_ADDR_RANGE_CFG, 8'h01);
        axisY = 12'hD7F;
        det(2'h1, 1'b0, 1'b0);
        chk(orientationChangeFlag, 1'b0);
        axisY = 12'hD80;
        det(2'h1, 1'b0, 1'b0);
        stat(8'h82);
        orientationDetectEnable = 1'b0;
        det(2'h3, 1'b1, 1'b0);
        chk({orientationChangeFlag, landscapePortraitField, backFrontBit}, 4'h2);
        orientationDetectEnable = 1'b1;
        orientIrqEnable = 1'b0;
        activeMode = 1'b0;
        repeat (2) @(negedge clk);
        activeMode = 1'b1;
        repeat (2) @(negedge clk);
        det(2'h0, 1'b0, 1'b0);
        chk({orientationChangeFlag, orientIrqSource}, 2'h2);
        rstchk();
        give_verdict();
    end
endmodule
